// *** pkg/mdt_pkg.sv ***
package mdt_pkg;
	// bus geometry
	localparam int unsigned ADDR_W      = 8;
	localparam int unsigned DATA_W      = 32;
	// register byte offsets
	localparam logic [7:0]  OFS_ASSERT  = 8'h00;
	localparam logic [7:0]  OFS_RECOV   = 8'h04;
	localparam logic [7:0]  OFS_MISC    = 8'h08;
	localparam logic [7:0]  OFS_ULTRA   = 8'h0c;
	localparam logic [7:0]  OFS_STATUS  = 8'h10;
	// writable bits per register, everything else reads zero
	localparam logic [31:0] MASK_MDMA   = 32'h0000_7f7f;
	localparam logic [31:0] MASK_MISC   = 32'h0000_0001;
	localparam logic [31:0] MASK_ULTRA  = 32'h0000_0f0f;
	localparam logic [31:0] RST_VAL     = 32'h0000_0000;
	// field positions
	localparam int unsigned FLD_W       = 7;
	localparam int unsigned SLV_LSB     = 8;
	localparam int unsigned MST_LSB     = 0;
	localparam int unsigned UFLD_W      = 4;
	localparam int unsigned OVR_BIT     = 0;
	// timing used while override is clear (cycles minus one)
	localparam logic [6:0]  DEF_ASSERT  = 7'h05;
	localparam logic [6:0]  DEF_RECOV   = 7'h03;
	localparam logic [3:0]  DEF_ULTRA   = 4'h3;
	// bus responses
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	// strobe phases
	typedef enum logic [1:0] {
		PH_IDLE    = 2'b00,
		PH_ASSERT  = 2'b01,
		PH_RECOVER = 2'b10
	} mdt_phase_t;
endpackage

// *** pkg/mdt_tim_if.sv ***
`timescale 1ns/1ns
interface mdt_tim_if;
	logic                  req;
	logic                  dir_write;
	logic [6:0]            assert_cnt;
	logic [6:0]            recov_cnt;
	logic                  rd_stb;
	logic                  wr_stb;
	logic                  busy;
	mdt_pkg::mdt_phase_t   phase;
	// register side drives timing and requests
	modport ctl (output req, dir_write, assert_cnt, recov_cnt,
		input rd_stb, wr_stb, busy, phase);
	// strobe sequencer side
	modport gen (input req, dir_write, assert_cnt, recov_cnt,
		output rd_stb, wr_stb, busy, phase);
endinterface

// *** logic/mdt_strobe_gen.sv ***
`timescale 1ns/1ns
module mdt_strobe_gen (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic ce,
	// timing and strobes
	mdt_tim_if.gen    tim
);
	typedef struct packed {
		mdt_pkg::mdt_phase_t phase;
		logic [6:0]          cnt;
		logic [6:0]          aw;
		logic [6:0]          rw;
		logic                rd;
		logic                wr;
		logic                busy;
	} mdt_gen_st_t;

	mdt_gen_st_t q_ff;
	mdt_gen_st_t nxt_q;

	// a strobe starts only from idle or from the last recovery cycle
	always_comb
	begin
		nxt_q = q_ff;
		if (ce)
		begin
			case (q_ff.phase)
				mdt_pkg::PH_IDLE,
				mdt_pkg::PH_RECOVER:
				begin
					if (q_ff.phase == mdt_pkg::PH_RECOVER && q_ff.cnt != 7'h00)
						nxt_q.cnt = q_ff.cnt - 7'h01;
					else if (tim.req)
					begin
						// widths latched here so a reprogram waits for the next strobe
						nxt_q.phase = mdt_pkg::PH_ASSERT;
						nxt_q.aw    = tim.assert_cnt;  // [RQ9]
						nxt_q.rw    = tim.recov_cnt;   // [RQ9]
						nxt_q.cnt   = tim.assert_cnt;  // [RQ3]
						nxt_q.rd    = !tim.dir_write;
						nxt_q.wr    = tim.dir_write;
					end
					else
						nxt_q.phase = mdt_pkg::PH_IDLE;
				end
				mdt_pkg::PH_ASSERT:
				begin
					if (q_ff.cnt == 7'h00)
					begin
						nxt_q.phase = mdt_pkg::PH_RECOVER; // [RQ4] [RQ5]
						nxt_q.cnt   = q_ff.rw;
						nxt_q.rd    = 1'b0;
						nxt_q.wr    = 1'b0;
					end
					else
						nxt_q.cnt = q_ff.cnt - 7'h01; // [RQ1] [RQ2]
				end
				default:
				begin
					nxt_q.phase = mdt_pkg::PH_IDLE;
					nxt_q.rd    = 1'b0;
					nxt_q.wr    = 1'b0;
				end
			endcase
			// busy kept as its own flop so the top output needs no decode after it
			nxt_q.busy = nxt_q.phase != mdt_pkg::PH_IDLE;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			q_ff <= '{mdt_pkg::PH_IDLE, 7'h00, 7'h00, 7'h00, 1'b0, 1'b0, 1'b0};
		else
			q_ff <= nxt_q;
	end

	assign tim.rd_stb = q_ff.rd;
	assign tim.wr_stb = q_ff.wr;
	assign tim.phase  = q_ff.phase;
	assign tim.busy   = q_ff.busy;

	// helper counters of enabled cycles spent high and in recovery
	logic       stb;
	logic [7:0] hi_run_ff;
	logic [7:0] lo_run_ff;
	assign stb = q_ff.rd | q_ff.wr;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			hi_run_ff <= 8'h00;
			lo_run_ff <= 8'h00;
		end
		else if (ce)
		begin
			hi_run_ff <= stb ? hi_run_ff + 8'h01 : 8'h00;
			lo_run_ff <= (q_ff.phase == mdt_pkg::PH_RECOVER) ? lo_run_ff + 8'h01 : 8'h00;
		end
	end

	sequence s_strobe_end;
		$fell(stb) ##0 (q_ff.phase == mdt_pkg::PH_RECOVER);
	endsequence

	chk_assert_width: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ1] [RQ2]
		s_strobe_end |-> hi_run_ff == {1'b0, q_ff.aw} + 8'h01)
		else $error("strobe width differs from latched field plus one");
	chk_recov_width: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ4] [RQ5]
		$rose(stb) && $past(q_ff.phase) == mdt_pkg::PH_RECOVER
			|-> $past(lo_run_ff) == {1'b0, $past(q_ff.rw)})
		else $error("recovery gap differs from latched field plus one");
	chk_zero_one_cycle: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ3]
		$rose(stb) && q_ff.aw == 7'h00 && ce |=> !stb)
		else $error("zero field did not give a single cycle strobe");
	chk_width_frozen: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ9]
		q_ff.phase != mdt_pkg::PH_IDLE && $past(q_ff.phase) != mdt_pkg::PH_IDLE
			&& !$rose(stb) |-> $stable(q_ff.aw) && $stable(q_ff.rw))
		else $error("timing changed in the middle of a strobe cycle");
	chk_one_strobe: assert property (@(posedge aclk) disable iff (!aresetn)
		!(q_ff.rd && q_ff.wr))
		else $error("read and write strobes both asserted");
endmodule

// *** logic/mdt_regs_top.sv ***
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
// Overview of operation
// [RQ1] slave strobe lasts slave field plus one
// [RQ2] master strobe lasts master field plus one
// [RQ3] field value zero means one cycle
// [RQ4] slave recovery lasts slave field plus one
// [RQ5] master recovery lasts master field plus one
// [RQ6] fields used only with override set
// [RQ7] reserved bits read zero, fields reset zero
// [RQ8] ultra half strobe from own register
// [RQ9] reserved writes ignored, changes wait next strobe
module mdt_regs_top (
	// clock, reset, enable
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	input  wire logic                         ce,
	// axi4-lite write address
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [mdt_pkg::ADDR_W-1:0]   s_axi_awaddr,
	// axi4-lite write data
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	input  wire logic [mdt_pkg::DATA_W-1:0]   s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	// axi4-lite write response
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	output logic [1:0]                        s_axi_bresp,
	// axi4-lite read address
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	input  wire logic [mdt_pkg::ADDR_W-1:0]   s_axi_araddr,
	// axi4-lite read data
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	output logic [mdt_pkg::DATA_W-1:0]        s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	// transfer engine side
	input  wire logic                         dma_req,
	input  wire logic                         dma_dir_write,
	input  wire logic                         dev_sel_slave,
	output logic                              dma_busy,
	output logic [3:0]                        ultra_half_strobe_width,
	// device strobes
	output logic                              host_read_strobe,
	output logic                              host_write_strobe
);
	typedef struct packed {
		logic                       awrdy;
		logic                       aw_have;
		logic [mdt_pkg::ADDR_W-1:0] aw_addr;
		logic                       wrdy;
		logic                       w_have;
		logic [31:0]                w_data;
		logic [3:0]                 w_strb;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic                       arrdy;
		logic                       rvalid;
		logic [31:0]                rdata;
		logic [1:0]                 rresp;
		logic [31:0]                asrt;
		logic [31:0]                recov;
		logic [31:0]                misc;
		logic [31:0]                ultra;
		logic [6:0]                 a_sel;
		logic [6:0]                 r_sel;
		logic [3:0]                 u_sel;
		logic                       req;
		logic                       dirw;
	} mdt_top_st_t;

	mdt_top_st_t q_ff;
	mdt_top_st_t nxt_q;
	mdt_tim_if   tim ();

	// byte-lane merge; bits outside the mask are dropped so reserved stay zero
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				res[8*i +: 8] = data[8*i +: 8];
		end
		return res & mask; // [RQ9] [RQ7]
	endfunction

	// bus slave, register file and timing selection in one next-state pass
	always_comb
	begin
		logic ovr;
		ovr   = 1'b0;
		nxt_q = q_ff;
		if (ce)
		begin
			ovr = q_ff.misc[mdt_pkg::OVR_BIT];
			if (s_axi_awvalid && q_ff.awrdy)
			begin
				nxt_q.aw_have = 1'b1;
				nxt_q.aw_addr = s_axi_awaddr;
			end
			if (s_axi_wvalid && q_ff.wrdy)
			begin
				nxt_q.w_have = 1'b1;
				nxt_q.w_data = s_axi_wdata;
				nxt_q.w_strb = s_axi_wstrb;
			end
			if (q_ff.bvalid && s_axi_bready)
				nxt_q.bvalid = 1'b0;
			// write commits once address and data are both held
			if (q_ff.aw_have && q_ff.w_have && !q_ff.bvalid)
			begin
				nxt_q.aw_have = 1'b0;
				nxt_q.w_have  = 1'b0;
				nxt_q.bvalid  = 1'b1;
				nxt_q.bresp   = mdt_pkg::RESP_OKAY;
				case (q_ff.aw_addr)
					mdt_pkg::OFS_ASSERT:
						nxt_q.asrt  = merge(q_ff.asrt, q_ff.w_data, q_ff.w_strb,
							mdt_pkg::MASK_MDMA);
					mdt_pkg::OFS_RECOV:
						nxt_q.recov = merge(q_ff.recov, q_ff.w_data, q_ff.w_strb,
							mdt_pkg::MASK_MDMA);
					mdt_pkg::OFS_MISC:
						nxt_q.misc  = merge(q_ff.misc, q_ff.w_data, q_ff.w_strb,
							mdt_pkg::MASK_MISC);
					mdt_pkg::OFS_ULTRA:
						nxt_q.ultra = merge(q_ff.ultra, q_ff.w_data, q_ff.w_strb,
							mdt_pkg::MASK_ULTRA);
					mdt_pkg::OFS_STATUS: ; // read only, write ignored
					default:
						nxt_q.bresp = mdt_pkg::RESP_SLVERR;
				endcase
			end
			if (q_ff.rvalid && s_axi_rready)
				nxt_q.rvalid = 1'b0;
			if (s_axi_arvalid && q_ff.arrdy)
			begin
				nxt_q.rvalid = 1'b1;
				nxt_q.rresp  = mdt_pkg::RESP_OKAY;
				case (s_axi_araddr)
					mdt_pkg::OFS_ASSERT: nxt_q.rdata = q_ff.asrt;
					mdt_pkg::OFS_RECOV:  nxt_q.rdata = q_ff.recov;
					mdt_pkg::OFS_MISC:   nxt_q.rdata = q_ff.misc;
					mdt_pkg::OFS_ULTRA:  nxt_q.rdata = q_ff.ultra;
					mdt_pkg::OFS_STATUS:
						nxt_q.rdata = {29'h0000_0000, tim.busy, tim.phase};
					default:
					begin
						nxt_q.rdata = mdt_pkg::RST_VAL;
						nxt_q.rresp = mdt_pkg::RESP_SLVERR;
					end
				endcase
			end
			nxt_q.awrdy = !nxt_q.aw_have && !nxt_q.bvalid;
			nxt_q.wrdy  = !nxt_q.w_have && !nxt_q.bvalid;
			nxt_q.arrdy = !nxt_q.rvalid;
			// programmed fields only count while override is set
			if (ovr) // [RQ6]
			begin
				if (dev_sel_slave)
				begin
					nxt_q.a_sel = q_ff.asrt[mdt_pkg::SLV_LSB +: mdt_pkg::FLD_W];   // [RQ1]
					nxt_q.r_sel = q_ff.recov[mdt_pkg::SLV_LSB +: mdt_pkg::FLD_W];  // [RQ4]
					nxt_q.u_sel = q_ff.ultra[mdt_pkg::SLV_LSB +: mdt_pkg::UFLD_W]; // [RQ8]
				end
				else
				begin
					nxt_q.a_sel = q_ff.asrt[mdt_pkg::MST_LSB +: mdt_pkg::FLD_W];   // [RQ2]
					nxt_q.r_sel = q_ff.recov[mdt_pkg::MST_LSB +: mdt_pkg::FLD_W];  // [RQ5]
					nxt_q.u_sel = q_ff.ultra[mdt_pkg::MST_LSB +: mdt_pkg::UFLD_W]; // [RQ8]
				end
			end
			else
			begin
				nxt_q.a_sel = mdt_pkg::DEF_ASSERT;
				nxt_q.r_sel = mdt_pkg::DEF_RECOV;
				nxt_q.u_sel = mdt_pkg::DEF_ULTRA;
			end
			nxt_q.req  = dma_req;
			nxt_q.dirw = dma_dir_write;
		end
	end

	// every register clears to zero, timing falls back to defaults
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q_ff       <= '0; // [RQ7]
			q_ff.a_sel <= mdt_pkg::DEF_ASSERT;
			q_ff.r_sel <= mdt_pkg::DEF_RECOV;
			q_ff.u_sel <= mdt_pkg::DEF_ULTRA;
		end
		else
			q_ff <= nxt_q;
	end

	// timing hand-off to the sequencer
	assign tim.req        = q_ff.req;
	assign tim.dir_write  = q_ff.dirw;
	assign tim.assert_cnt = q_ff.a_sel;
	assign tim.recov_cnt  = q_ff.r_sel;

	mdt_strobe_gen u_gen (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.tim     (tim)
	);

	// outputs, all from flip-flops
	assign s_axi_awready           = q_ff.awrdy;
	assign s_axi_wready            = q_ff.wrdy;
	assign s_axi_bvalid            = q_ff.bvalid;
	assign s_axi_bresp             = q_ff.bresp;
	assign s_axi_arready           = q_ff.arrdy;
	assign s_axi_rvalid            = q_ff.rvalid;
	assign s_axi_rdata             = q_ff.rdata;
	assign s_axi_rresp             = q_ff.rresp;
	assign ultra_half_strobe_width = q_ff.u_sel;
	assign dma_busy                = tim.busy;
	assign host_read_strobe        = tim.rd_stb;
	assign host_write_strobe       = tim.wr_stb;

	sequence s_wr_both;
		ce && q_ff.aw_have && q_ff.w_have && !q_ff.bvalid;
	endsequence

	chk_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
		s_wr_both |=> s_axi_bvalid ##0 !q_ff.aw_have)
		else $error("write response missing after address and data");
	chk_rsvd_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ7]
		(q_ff.asrt & ~mdt_pkg::MASK_MDMA) == 32'h0 && (q_ff.recov & ~mdt_pkg::MASK_MDMA) == 32'h0)
		else $error("reserved timing bits became set");
	chk_override_off: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ6]
		ce && !q_ff.misc[mdt_pkg::OVR_BIT] |=> tim.assert_cnt == mdt_pkg::DEF_ASSERT
			&& tim.recov_cnt == mdt_pkg::DEF_RECOV)
		else $error("programmed timing used without override");
	chk_slave_sel: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ1]
		ce && q_ff.misc[mdt_pkg::OVR_BIT] && dev_sel_slave
			|=> tim.assert_cnt == $past(q_ff.asrt[mdt_pkg::SLV_LSB +: mdt_pkg::FLD_W])
			&& tim.recov_cnt == $past(q_ff.recov[mdt_pkg::SLV_LSB +: mdt_pkg::FLD_W]))
		else $error("slave timing field not selected");
	chk_master_sel: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ2]
		ce && q_ff.misc[mdt_pkg::OVR_BIT] && !dev_sel_slave
			|=> tim.assert_cnt == $past(q_ff.asrt[mdt_pkg::MST_LSB +: mdt_pkg::FLD_W])
			&& tim.recov_cnt == $past(q_ff.recov[mdt_pkg::MST_LSB +: mdt_pkg::FLD_W]))
		else $error("master timing field not selected");
	chk_ultra_sel: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ8]
		ce && q_ff.misc[mdt_pkg::OVR_BIT] |=> ultra_half_strobe_width ==
			($past(dev_sel_slave) ? $past(q_ff.ultra[mdt_pkg::SLV_LSB +: mdt_pkg::UFLD_W])
			: $past(q_ff.ultra[mdt_pkg::MST_LSB +: mdt_pkg::UFLD_W])))
		else $error("ultra half strobe width not taken from its register");
	chk_reset_clear: assert property (@(posedge aclk) // [RQ7]
		!aresetn |=> q_ff.asrt == 32'h0 && q_ff.recov == 32'h0 && q_ff.misc == 32'h0)
		else $error("timing registers not zero after reset");
	chk_read_order: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data did not follow the read address");
endmodule

// *** verif/mdt_dev_model.sv ***
`timescale 1ns/1ns
// attached drive: only watches the strobes and times each high and low run
module mdt_dev_model (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// strobes from the controller
	input  wire logic host_read_strobe,
	input  wire logic host_write_strobe
);
	int   hi_run;
	int   lo_run;
	int   hi_w;
	int   lo_w;
	int   pulses;
	logic prev;
	logic last_wr;
	logic s;
	assign s = host_read_strobe | host_write_strobe;
	// results move by nba so the bench reads them race free at the edge
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			prev <= 1'b0;
			pulses <= 0;
			hi_run <= 0;
			lo_run <= 0;
		end
		else
		begin
			prev <= s;
			if (s)
			begin
				hi_run <= prev ? hi_run + 1 : 1;
				if (!prev)
					lo_w <= lo_run; // gap before this rise
				last_wr <= host_write_strobe;
			end
			else
			begin
				lo_run <= prev ? 1 : lo_run + 1;
				if (prev)
				begin
					hi_w <= hi_run;
					pulses <= pulses + 1;
				end
			end
		end
	end
endmodule

// *** verif/tb_mdma_strobe_recovery_timing.sv ***
`timescale 1ns/1ns
module tb_mdma_strobe_recovery_timing;
	logic                aclk    = 1'b0;
	logic                aresetn = 1'b0;
	logic                awvalid = 1'b0;
	logic                wvalid  = 1'b0;
	logic                bready  = 1'b0;
	logic                arvalid = 1'b0;
	logic                rready  = 1'b0;
	logic                dma_req = 1'b0;
	logic                dir_wr  = 1'b0;
	logic                slv     = 1'b0;
	logic                ce      = 1'b1;
	logic [7:0]          awaddr  = 8'h00;
	logic [7:0]          araddr  = 8'h00;
	logic [31:0]         wdata   = 32'h0;
	logic [15:0]         lfsr    = 16'h005d;
	wire logic           awready, wready, bvalid, arready, rvalid, busy, hrs, hws;
	wire logic [1:0]     bresp, rresp;
	wire logic [31:0]    rdata;
	wire logic [3:0]     ultra;
	logic [31:0]         mdl [8];
	logic [7:0]          addrs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
	logic [31:0]         d;
	logic [31:0]         q;
	logic [1:0]          rs;
	int                  err_total = 0;
	int                  checks = 0;
	int                  cyc = 0;
	int                  i, a, r, p;
	bit                  s;

	mdt_regs_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .dma_req(dma_req),
		.dma_dir_write(dir_wr), .dev_sel_slave(slv), .dma_busy(busy),
		.ultra_half_strobe_width(ultra), .host_read_strobe(hrs),
		.host_write_strobe(hws));
	mdt_dev_model model (.aclk(aclk), .aresetn(aresetn), .host_read_strobe(hrs),
		.host_write_strobe(hws));

	always #20 aclk = ~aclk;
	// hang guard, longest burst pair is about five hundred cycles
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 50000)
		begin
			err_total++;
			tally_and_finish();
		end
	end

	function automatic logic [15:0] nxt_rand();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction
	// writable bits per register in the reference model
	function automatic logic [31:0] msk(input logic [7:0] ad);
		case (ad)
			8'h00, 8'h04: return mdt_pkg::MASK_MDMA;
			8'h08: return mdt_pkg::MASK_MISC;
			8'h0c: return mdt_pkg::MASK_ULTRA;
			default: return 32'h0;
		endcase
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// aw and w offered together, each released when taken; bready stays high
	task automatic wr(input logic [7:0] ad, input logic [31:0] dat, output logic [1:0] rsp);
		bit a_ok;
		bit w_ok;
		a_ok = 0;
		w_ok = 0;
		awaddr <= ad;
		wdata <= dat;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(a_ok && w_ok))
		begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1)
			begin
				a_ok = 1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready === 1'b1)
			begin
				w_ok = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		rsp = bresp;
		if (msk(ad) != 32'h0)
			mdl[ad[4:2]] = dat & msk(ad);
	endtask
	task automatic rd(input logic [7:0] ad, output logic [31:0] dat, output logic [1:0] rsp);
		araddr <= ad;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		dat = rdata;
		rsp = rresp;
	endtask
	// write then read back against the model; unmapped places answer slverr
	task automatic reg_rw(input logic [7:0] ad, input logic [31:0] dat);
		logic [1:0] er;
		er = (ad > 8'h10) ? mdt_pkg::RESP_SLVERR : mdt_pkg::RESP_OKAY;
		wr(ad, dat, rs);
		chk("bresp", 32'(er), 32'(rs));
		rd(ad, q, rs);
		chk("rresp", 32'(er), 32'(rs));
		chk("rdata", mdl[ad[4:2]], q);
	endtask
	// run strobes until two full pulses are timed, then stop the burst
	task automatic burst(input bit sl, input bit w, input int aw, input int rw);
		int p0;
		p0 = model.pulses;
		slv <= sl;
		dir_wr <= w;
		dma_req <= 1'b1;
		do @(posedge aclk); while (model.pulses < p0 + 2);
		dma_req <= 1'b0;
		chk("high width", 32'(aw + 1), 32'(model.hi_w));
		chk("low width", 32'(rw + 1), 32'(model.lo_w));
		chk("strobe kind", 32'(w), 32'(model.last_wr));
		chk("busy in burst", 32'h1, 32'(busy));
		do @(posedge aclk); while (busy !== 1'b0);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		for (i = 0; i < 8; i++)
			mdl[i] = 32'h0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		bready <= 1'b1;
		rready <= 1'b1;
		repeat (2) @(posedge aclk);
		// reset values, then all ones and random words through every place
		for (i = 0; i < 6; i++)
		begin
			rd(addrs[i], q, rs);
			chk("reset value", 32'h0, q);
			reg_rw(addrs[i], 32'hffff_ffff);
			reg_rw(addrs[i], {nxt_rand(), nxt_rand()});
		end
		// override clear: programmed fields must not matter
		wr(8'h08, 32'h0, rs);
		burst(1'b0, 1'b1, int'(mdt_pkg::DEF_ASSERT), int'(mdt_pkg::DEF_RECOV));
		chk("ultra default", 32'(mdt_pkg::DEF_ULTRA), 32'(ultra));
		// clock enable low: a held request must not start a strobe
		p = model.pulses;
		ce <= 1'b0;
		dma_req <= 1'b1;
		repeat (8) @(posedge aclk);
		chk("frozen pulses", 32'(p), 32'(model.pulses));
		chk("frozen busy", 32'h0, 32'(busy));
		ce <= 1'b1;
		dma_req <= 1'b0;
		wr(8'h08, 32'h1, rs);
		// both devices, both directions, boundary and random counts
		for (i = 0; i < 6; i++)
		begin
			s = i[0];
			a = (i == 0) ? 0 : (i == 1) ? 127 : int'(nxt_rand() % 16'd64);
			r = (i == 0) ? 0 : (i == 1) ? 127 : int'(nxt_rand() % 16'd64);
			d = {nxt_rand(), nxt_rand()};
			d[(s ? 8 : 0) +: 7] = 7'(a);
			wr(8'h00, d, rs);
			d = {nxt_rand(), nxt_rand()};
			d[(s ? 8 : 0) +: 7] = 7'(r);
			wr(8'h04, d, rs);
			burst(s, i[1], a, r);
		end
		// ultra half strobe picked per device
		d = {nxt_rand(), nxt_rand()};
		wr(8'h0c, d, rs);
		slv <= 1'b0;
		repeat (3) @(posedge aclk);
		chk("ultra master", 32'(d[3:0]), 32'(ultra));
		slv <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("ultra slave", 32'(d[11:8]), 32'(ultra));
		// second reset in mid-run: programmed timing and override clear again
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		for (i = 0; i < 4; i++)
		begin
			rd(addrs[i], q, rs);
			chk("value after reset", 32'h0, q);
		end
		chk("ultra after reset", 32'(mdt_pkg::DEF_ULTRA), 32'(ultra));
		tally_and_finish();
	end
endmodule
